// ===== core/cnu_cycle_tick.sv
// Program cycle divider producing a one-clock enable
`timescale 1ns/1ps
`default_nettype none
module cnu_cycle_tick #(
    parameter int unsigned CLKS = 200000
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);
    logic [31:0] cnt_q;

    // Free running count, tick on the last clock of each cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 32'h0;
        end else if (cnt_q >= 32'(CLKS - 1)) begin
            cnt_q <= 32'h0;
        end else begin
            cnt_q <= cnt_q + 32'h1;
        end
    end

    assign tick = (cnt_q >= 32'(CLKS - 1));
endmodule : cnu_cycle_tick
`default_nettype wire

// ===== core/cnu_pkg.sv
// Constants and types of the neutral unbalance status block
// What this block does
// - Condition code reads 0 normal, 1 start, 2 trip, 3 blocked.
// - Logical node code reads 1 on, 2 blocked, 3 test, 4 test/blocked, 5 off.
// - Unbalance current shown in 0.01 A, angle in 0.01 degree.
// - Remaining alarm time counts down in 5 ms steps, up to 1800 s.
// - Remaining trip time counts down in 5 ms steps while timing a trip.
// - Expected alarm and trip times shown, refreshed every program cycle.
// - Measured over alarm and trip set values shown as ratios, 0.01 steps.
// - Block input is sampled once at each program cycle start, before evaluation.
// - External block input is combined with the optional inrush harmonic block.
// - Pick-up without blocking raises start and begins operate timing.
// - Pick-up with blocking raises blocked and nothing further happens.
// - Blocking during start drops start and releases timers like a pick-up reset.
// - Blocking issues a display event and stamped event with current and type.
// - Inrush harmonic blocking enable, 0 off, 1 on, reset off.
// - With inrush enabled, harmonic ratio above the limit blocks the stage.
// - In stage forcing mode a software switch asserts blocking.
// - Alarm and trip timers use definite time delays.
// - Pick-up alone is not start; start only when no blocking is active.
package cnu_pkg;
    // Program cycle is also the display resolution of all times
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned CYCLE_TIME_MS = 5;
    localparam int unsigned CYCLE_CLKS = CYCLE_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned MAX_TIME_S = 1800;
    localparam logic [18:0] MAX_TIME_CYC = 19'(MAX_TIME_S * 1000 / CYCLE_TIME_MS);
    localparam int TW = 19;
    localparam int VW = 16;
    localparam int RW = 17;
    localparam logic [23:0] RATIO_SCALE = 24'h64;
    localparam logic [RW-1:0] RATIO_UNITY = 17'h00064;
    localparam logic [RW-1:0] RATIO_MAX = 17'h1e848;
    // Register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ISET_ALARM = 8'h04;
    localparam logic [7:0] REG_ISET_TRIP = 8'h08;
    localparam logic [7:0] REG_HARM_LIMIT = 8'h0c;
    localparam logic [7:0] REG_DELAY_ALARM = 8'h10;
    localparam logic [7:0] REG_DELAY_TRIP = 8'h14;
    localparam logic [7:0] REG_STATUS = 8'h18;
    localparam logic [7:0] REG_MEAS = 8'h1c;
    localparam logic [7:0] REG_REM_ALARM = 8'h20;
    localparam logic [7:0] REG_REM_TRIP = 8'h24;
    localparam logic [7:0] REG_EXP_ALARM = 8'h28;
    localparam logic [7:0] REG_EXP_TRIP = 8'h2c;
    localparam logic [7:0] REG_RATIO_ALARM = 8'h30;
    localparam logic [7:0] REG_RATIO_TRIP = 8'h34;
    localparam logic [7:0] REG_BLK_EVT = 8'h38;
    // Field positions
    localparam int CTRL_INRUSH_BIT = 0;
    localparam int CTRL_FORCE_EN_BIT = 1;
    localparam int CTRL_FORCE_BLK_BIT = 2;
    localparam int CTRL_LN_LSB = 4;
    localparam int ST_COND_LSB = 0;
    localparam int ST_LN_LSB = 4;
    localparam int ST_START_BIT = 8;
    localparam int ST_TRIP_BIT = 9;
    localparam int ST_BLOCKED_BIT = 10;
    localparam int ST_ALARM_BIT = 11;
    localparam int MEAS_ANG_LSB = 16;
    localparam int EVT_TYPE_LSB = 16;
    // Reset values
    localparam logic [VW-1:0] ISET_ALARM_RST = 16'h000a;
    localparam logic [VW-1:0] ISET_TRIP_RST = 16'h0014;
    localparam logic [VW-1:0] HARM_LIMIT_RST = 16'h0001;
    localparam logic [TW-1:0] DELAY_RST = 19'h003e8;
    // Condition and logical node codes
    localparam logic [1:0] COND_NORMAL = 2'h0;
    localparam logic [1:0] COND_START = 2'h1;
    localparam logic [1:0] COND_TRIP = 2'h2;
    localparam logic [1:0] COND_BLOCKED = 2'h3;
    localparam logic [2:0] LN_ON = 3'h1;
    localparam logic [2:0] LN_BLOCKED = 3'h2;
    localparam logic [2:0] LN_TEST = 3'h3;
    localparam logic [2:0] LN_TEST_BLK = 3'h4;
    localparam logic [2:0] LN_OFF = 3'h5;
    typedef enum logic [1:0] {ST_NORMAL, ST_START, ST_TRIP, ST_BLOCKED} cnu_state_t;
endpackage : cnu_pkg

// ===== core/cnu_status.sv
// Neutral unbalance stage status, blocking and definite time logic
`timescale 1ns/1ps
`default_nettype none
module cnu_status #(
    parameter int unsigned CYCLE_CLKS_P = cnu_pkg::CYCLE_CLKS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic block_in,
    input wire logic [cnu_pkg::VW-1:0] unb_cur,
    input wire logic [cnu_pkg::VW-1:0] unb_ang,
    input wire logic [cnu_pkg::VW-1:0] harm_ratio,
    output logic sig_start,
    output logic sig_trip,
    output logic sig_blocked,
    output logic sig_alarm,
    output logic [1:0] cond,
    output logic [2:0] ln_mode,
    output logic disp_evt,
    output logic blk_evt,
    output logic [cnu_pkg::VW-1:0] blk_evt_cur,
    output logic [1:0] blk_evt_type,
    output logic [31:0] blk_evt_stamp
);
    import cnu_pkg::*;

    logic tick;
    logic eval_q;
    logic blk_smp_q;
    logic [VW-1:0] cur_q;
    logic [VW-1:0] ang_q;
    logic [VW-1:0] harm_q;
    logic inrush_en_q;
    logic force_en_q;
    logic force_blk_q;
    logic [2:0] ln_q;
    logic [VW-1:0] iset_a_q;
    logic [VW-1:0] iset_t_q;
    logic [VW-1:0] harm_lim_q;
    logic [TW-1:0] delay_a_q;
    logic [TW-1:0] delay_t_q;
    logic [RW-1:0] ratio_a_q;
    logic [RW-1:0] ratio_t_q;
    logic [TW-1:0] rem_a_q;
    logic [TW-1:0] rem_t_q;
    logic [TW-1:0] exp_a_q;
    logic [TW-1:0] exp_t_q;
    logic alarm_q;
    logic [31:0] stamp_q;
    logic [31:0] rdata_d;
    logic mapped;
    cnu_state_t state_q;
    cnu_state_t state_d;
    logic alarm_pick;
    logic trip_pick;
    logic pick;
    logic inrush_blk;
    logic forced_blk;
    logic ln_blk;
    logic ln_off;
    logic blk_now;
    logic act_q;
    logic act_d;
    logic wr_en;

    // Ratio of measured to set value in 0.01 units, saturated
    function automatic logic [RW-1:0] ratio_of(input logic [VW-1:0] m, input logic [VW-1:0] s);
        logic [23:0] q;
        q = (s == '0) ? 24'(RATIO_MAX) : (24'(m) * RATIO_SCALE) / 24'(s);
        return (q > 24'(RATIO_MAX)) ? RATIO_MAX : q[RW-1:0];
    endfunction : ratio_of

    cnu_cycle_tick #(
        .CLKS(CYCLE_CLKS_P)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    // Sample inputs at cycle start; evaluation follows one clock later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eval_q <= 1'b0;
            blk_smp_q <= 1'b0;
            cur_q <= '0;
            ang_q <= '0;
            harm_q <= '0;
            ratio_a_q <= '0;
            ratio_t_q <= '0;
        end else begin
            eval_q <= tick;
            if (tick) begin
                blk_smp_q <= block_in;
                cur_q <= unb_cur;
                ang_q <= unb_ang;
                harm_q <= harm_ratio;
                ratio_a_q <= ratio_of(unb_cur, iset_a_q);
                ratio_t_q <= ratio_of(unb_cur, iset_t_q);
            end
        end
    end

    // Pick-up follows the ratios; it is not start by itself
    assign alarm_pick = (ratio_a_q >= RATIO_UNITY);
    assign trip_pick = (ratio_t_q >= RATIO_UNITY);
    assign pick = alarm_pick | trip_pick;

    // Blocking sources merged into one level
    assign inrush_blk = inrush_en_q && (harm_q > harm_lim_q);
    assign forced_blk = force_en_q && force_blk_q;
    assign ln_blk = (ln_q == LN_BLOCKED) || (ln_q == LN_TEST_BLK);
    assign ln_off = (ln_q == LN_OFF);
    assign blk_now = blk_smp_q | inrush_blk | forced_blk | ln_blk;

    // Next stage condition
    always_comb begin
        state_d = state_q;
        if (ln_off) begin
            state_d = ST_NORMAL;
        end else begin
            case (state_q)
                ST_NORMAL, ST_BLOCKED: begin
                    if (!pick) begin
                        state_d = ST_NORMAL;
                    end else if (blk_now) begin
                        state_d = ST_BLOCKED;
                    end else begin
                        state_d = ST_START;
                    end
                end
                ST_START: begin
                    if (!pick) begin
                        state_d = ST_NORMAL;
                    end else if (blk_now) begin
                        state_d = ST_BLOCKED;
                    end else if (trip_pick && rem_t_q <= 19'h1) begin
                        state_d = ST_TRIP;
                    end
                end
                ST_TRIP: begin
                    if (!pick) begin
                        state_d = ST_NORMAL;
                    end else if (blk_now) begin
                        state_d = ST_BLOCKED;
                    end else if (!trip_pick) begin
                        state_d = ST_START;
                    end
                end
                default: begin
                    state_d = ST_NORMAL;
                end
            endcase
        end
    end

    assign act_q = (state_q == ST_START) || (state_q == ST_TRIP);
    assign act_d = (state_d == ST_START) || (state_d == ST_TRIP);

    // Condition register, moves only on evaluation clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_NORMAL;
        end else if (eval_q) begin
            state_q <= state_d;
        end
    end

    // Trip timer: load on start, reload when trip pick-up drops, clear on release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rem_t_q <= '0;
        end else if (eval_q) begin
            if (!act_d) begin
                rem_t_q <= '0;
            end else if (!act_q || !trip_pick) begin
                rem_t_q <= delay_t_q;
            end else if (rem_t_q != '0) begin
                rem_t_q <= rem_t_q - 19'h1;
            end
        end
    end

    // Alarm timer runs beside the trip timer on its own delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rem_a_q <= '0;
            alarm_q <= 1'b0;
        end else if (eval_q) begin
            if (!act_d) begin
                rem_a_q <= '0;
                alarm_q <= 1'b0;
            end else if (!act_q || !alarm_pick) begin
                rem_a_q <= delay_a_q;
                alarm_q <= 1'b0;
            end else begin
                if (rem_a_q != '0) begin
                    rem_a_q <= rem_a_q - 19'h1;
                end
                if (rem_a_q <= 19'h1) begin
                    alarm_q <= 1'b1;
                end
            end
        end
    end

    // Only definite time exists, so expected times follow the delays each cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            exp_a_q <= DELAY_RST;
            exp_t_q <= DELAY_RST;
        end else if (eval_q) begin
            exp_a_q <= delay_a_q;
            exp_t_q <= delay_t_q;
        end
    end

    // Cycle count used as the event time stamp
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stamp_q <= 32'h0;
        end else if (tick) begin
            stamp_q <= stamp_q + 32'h1;
        end
    end

    // Blocking events carry current and which pick-ups were active
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disp_evt <= 1'b0;
            blk_evt <= 1'b0;
            blk_evt_cur <= '0;
            blk_evt_type <= 2'h0;
            blk_evt_stamp <= 32'h0;
        end else begin
            disp_evt <= 1'b0;
            blk_evt <= 1'b0;
            if (eval_q && state_d == ST_BLOCKED && state_q != ST_BLOCKED) begin
                disp_evt <= 1'b1;
                blk_evt <= 1'b1;
                blk_evt_cur <= cur_q;
                blk_evt_type <= {trip_pick, alarm_pick};
                blk_evt_stamp <= stamp_q;
            end
        end
    end

    // Stage outputs and codes
    assign sig_start = act_q;
    assign sig_trip = (state_q == ST_TRIP);
    assign sig_blocked = (state_q == ST_BLOCKED);
    assign sig_alarm = alarm_q;
    assign cond = state_q;
    assign ln_mode = ln_q;

    // APB slave with zero wait states
    assign wr_en = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // Settings written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inrush_en_q <= 1'b0;
            force_en_q <= 1'b0;
            force_blk_q <= 1'b0;
            ln_q <= LN_ON;
            iset_a_q <= ISET_ALARM_RST;
            iset_t_q <= ISET_TRIP_RST;
            harm_lim_q <= HARM_LIMIT_RST;
            delay_a_q <= DELAY_RST;
            delay_t_q <= DELAY_RST;
        end else if (wr_en) begin
            case (paddr)
                REG_CTRL: begin
                    inrush_en_q <= pwdata[CTRL_INRUSH_BIT];
                    force_en_q <= pwdata[CTRL_FORCE_EN_BIT];
                    force_blk_q <= pwdata[CTRL_FORCE_BLK_BIT];
                    // Codes outside 1..5 are ignored so the mode stays legal
                    if (pwdata[CTRL_LN_LSB +: 3] >= LN_ON && pwdata[CTRL_LN_LSB +: 3] <= LN_OFF) begin
                        ln_q <= pwdata[CTRL_LN_LSB +: 3];
                    end
                end
                REG_ISET_ALARM: iset_a_q <= pwdata[VW-1:0];
                REG_ISET_TRIP: iset_t_q <= pwdata[VW-1:0];
                REG_HARM_LIMIT: harm_lim_q <= pwdata[VW-1:0];
                REG_DELAY_ALARM: begin
                    delay_a_q <= (pwdata > 32'(MAX_TIME_CYC)) ? MAX_TIME_CYC : pwdata[TW-1:0];
                end
                REG_DELAY_TRIP: begin
                    delay_t_q <= (pwdata > 32'(MAX_TIME_CYC)) ? MAX_TIME_CYC : pwdata[TW-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Read mux; unmapped addresses read zero and flag an error
    always_comb begin
        rdata_d = 32'h0;
        mapped = 1'b1;
        case (paddr)
            REG_CTRL: begin
                rdata_d[CTRL_INRUSH_BIT] = inrush_en_q;
                rdata_d[CTRL_FORCE_EN_BIT] = force_en_q;
                rdata_d[CTRL_FORCE_BLK_BIT] = force_blk_q;
                rdata_d[CTRL_LN_LSB +: 3] = ln_q;
            end
            REG_ISET_ALARM: rdata_d[VW-1:0] = iset_a_q;
            REG_ISET_TRIP: rdata_d[VW-1:0] = iset_t_q;
            REG_HARM_LIMIT: rdata_d[VW-1:0] = harm_lim_q;
            REG_DELAY_ALARM: rdata_d[TW-1:0] = delay_a_q;
            REG_DELAY_TRIP: rdata_d[TW-1:0] = delay_t_q;
            REG_STATUS: begin
                rdata_d[ST_COND_LSB +: 2] = state_q;
                rdata_d[ST_LN_LSB +: 3] = ln_q;
                rdata_d[ST_START_BIT] = sig_start;
                rdata_d[ST_TRIP_BIT] = sig_trip;
                rdata_d[ST_BLOCKED_BIT] = sig_blocked;
                rdata_d[ST_ALARM_BIT] = alarm_q;
            end
            REG_MEAS: rdata_d = {ang_q, cur_q};
            REG_REM_ALARM: rdata_d[TW-1:0] = rem_a_q;
            REG_REM_TRIP: rdata_d[TW-1:0] = rem_t_q;
            REG_EXP_ALARM: rdata_d[TW-1:0] = exp_a_q;
            REG_EXP_TRIP: rdata_d[TW-1:0] = exp_t_q;
            REG_RATIO_ALARM: rdata_d[RW-1:0] = ratio_a_q;
            REG_RATIO_TRIP: rdata_d[RW-1:0] = ratio_t_q;
            REG_BLK_EVT: begin
                rdata_d[VW-1:0] = blk_evt_cur;
                rdata_d[EVT_TYPE_LSB +: 2] = blk_evt_type;
            end
            default: mapped = 1'b0;
        endcase
    end

    // Read data is captured in the setup phase so it is a flop in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdata_d;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_cond_trip: assert property (sig_trip |-> cond == COND_TRIP)
        else $error("trip shown with wrong condition code");
    a_ln_legal: assert property (ln_mode >= LN_ON && ln_mode <= LN_OFF)
        else $error("logical node code out of range");
    a_meas_take: assert property (tick |=> cur_q == $past(unb_cur))
        else $error("current not captured at cycle start");
    a_alarm_count: assert property (eval_q && act_q && act_d && alarm_pick && rem_a_q > 19'h1
        |=> rem_a_q == $past(rem_a_q) - 19'h1)
        else $error("alarm remaining time did not step down");
    a_trip_count: assert property (eval_q && act_q && act_d && trip_pick && rem_t_q > 19'h1
        |=> rem_t_q == $past(rem_t_q) - 19'h1)
        else $error("trip remaining time did not step down");
    a_exp_follow: assert property (eval_q |=> exp_t_q == $past(delay_t_q))
        else $error("expected trip time not refreshed");
    a_ratio_cap: assert property (ratio_a_q <= RATIO_MAX && ratio_t_q <= RATIO_MAX)
        else $error("ratio above saturation");
    a_block_sample: assert property (tick |=> blk_smp_q == $past(block_in) && eval_q)
        else $error("block not sampled before evaluation");
    a_start_free: assert property (eval_q && !ln_off && state_q == ST_NORMAL && pick && !blk_now
        |=> sig_start && rem_t_q == $past(delay_t_q))
        else $error("unblocked pick-up did not start timing");
    a_pick_blocked: assert property (eval_q && !ln_off && pick && blk_now
        |=> sig_blocked && !sig_start ##0 rem_t_q == '0)
        else $error("blocked pick-up still started or kept timer");
    a_block_event: assert property ($rose(sig_blocked) |-> blk_evt && disp_evt
        && blk_evt_cur == cur_q)
        else $error("blocking gave no event");
    a_inrush_blk: assert property (inrush_en_q && harm_q > harm_lim_q |-> blk_now)
        else $error("inrush harmonic did not block");
    a_trip_due: assert property (eval_q && !ln_off && state_q == ST_START && pick && !blk_now
        && trip_pick && rem_t_q <= 19'h1 |=> sig_trip)
        else $error("trip not issued at end of delay");
    a_rem_clear: assert property (!sig_start |-> rem_t_q == '0 && rem_a_q == '0)
        else $error("remaining time left after release");

    c_trip: cover property (sig_start ##1 sig_trip);
    c_block_start: cover property (sig_start ##1 sig_blocked);
    c_inrush: cover property (eval_q && inrush_blk && pick);
    c_alarm: cover property ($rose(sig_alarm));
endmodule : cnu_status
`default_nettype wire

// ===== dv/cnu_blk_src.sv
// Model of the blocking matrix and logic signals feeding the stage
`timescale 1ns/1ps
`default_nettype none
module cnu_blk_src (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic want_blk,
    input wire logic [cnu_pkg::VW-1:0] want_cur,
    input wire logic [cnu_pkg::VW-1:0] want_ang,
    input wire logic [cnu_pkg::VW-1:0] want_harm,
    output logic block_in,
    output logic [cnu_pkg::VW-1:0] unb_cur,
    output logic [cnu_pkg::VW-1:0] unb_ang,
    output logic [cnu_pkg::VW-1:0] harm_ratio
);
    import cnu_pkg::*;
    // Levels move just after an edge; the matrix shares the stage clock, so no glitches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_in <= 1'b0;
            unb_cur <= '0;
            unb_ang <= '0;
            harm_ratio <= '0;
        end else begin
            block_in <= want_blk; // Held as a level, raised well ahead of expiry
            unb_cur <= want_cur;
            unb_ang <= want_ang;
            harm_ratio <= want_harm;
        end
    end
endmodule : cnu_blk_src
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the neutral unbalance status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module testbench;
    import cnu_pkg::*;
    // Short program cycle keeps the run brief
    localparam int CYC = 16;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, want_blk = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, last_err, block_in, sig_start, sig_trip, sig_blocked, sig_alarm;
    logic disp_evt, blk_evt;
    logic [31:0] blk_evt_stamp, stamp0;
    time t0;
    logic [VW-1:0] want_cur = '0, want_ang = '0, want_harm = '0;
    logic [VW-1:0] unb_cur, unb_ang, harm_ratio, blk_evt_cur;
    logic [1:0] cond, blk_evt_type;
    logic [2:0] ln_mode;
    int n_errors = 0, checks = 0, cycles = 0, n, na;
    // Settings steps: control word, harmonic ratio, expected condition
    logic [7:0] t_ctrl [10] = '{8'h10, 8'h11, 8'h11, 8'h14, 8'h16,
                                8'h10, 8'h20, 8'h30, 8'h40, 8'h50};
    logic [15:0] t_harm [10] = '{16'd51, 16'd51, 16'd50, 16'd50, 16'd50,
                                 16'd50, 16'd50, 16'd50, 16'd50, 16'd50};
    logic [1:0] t_cond [10] = '{COND_START, COND_BLOCKED, COND_START, COND_START, COND_BLOCKED,
                                COND_START, COND_BLOCKED, COND_START, COND_BLOCKED, COND_NORMAL};

    cnu_status #(.CYCLE_CLKS_P(CYC)) i_dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .block_in(block_in), .unb_cur(unb_cur), .unb_ang(unb_ang), .harm_ratio(harm_ratio),
        .sig_start(sig_start), .sig_trip(sig_trip), .sig_blocked(sig_blocked),
        .sig_alarm(sig_alarm), .cond(cond), .ln_mode(ln_mode), .disp_evt(disp_evt),
        .blk_evt(blk_evt), .blk_evt_cur(blk_evt_cur), .blk_evt_type(blk_evt_type),
        .blk_evt_stamp(blk_evt_stamp));
    cnu_blk_src i_src (
        .pclk(pclk), .presetn(presetn), .want_blk(want_blk), .want_cur(want_cur),
        .want_ang(want_ang), .want_harm(want_harm), .block_in(block_in), .unb_cur(unb_cur),
        .unb_ang(unb_ang), .harm_ratio(harm_ratio));

    initial begin
        forever #12.5 pclk = ~pclk;
    end

    // Cut a hang short; the whole sequence needs well under this
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 6000) begin
            n_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (n_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // One APB transfer: setup, then access held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask : rchk

    function automatic logic pick(input int sel);
        case (sel)
            0: return sig_start;
            1: return blk_evt;
            default: return sig_trip;
        endcase
    endfunction : pick

    // Bounded wait, sampling just after each edge has settled
    task automatic wait_for(input int sel);
        n = 0;
        while (pick(sel) !== 1'b1 && n < 8*CYC) begin
            @(posedge pclk);
            #1;
            n++;
        end
    endtask : wait_for

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rchk(REG_CTRL, 32'h10);
        rchk(REG_HARM_LIMIT, 32'h1);
        rchk(REG_STATUS, 32'h10);
        rchk(8'h3c, 32'h0);
        `CHK(last_err, 1'b1)
        apb(1'b1, REG_DELAY_ALARM, 32'd2);
        apb(1'b1, REG_DELAY_TRIP, 32'd4);
        want_cur <= 16'd30;
        want_ang <= 16'hf000;
        wait_for(0);
        na = 0;
        // Alarm and trip must land exactly two and four program cycles after start
        for (int i = 1; i <= 4*CYC; i++) begin
            @(posedge pclk);
            #1;
            if (sig_alarm === 1'b1 && na == 0) na = i;
            if (i == 4*CYC - 1) `CHK(sig_trip, 1'b0)
        end
        `CHK(sig_trip, 1'b1)
        `CHK(na, 2*CYC)
        `CHK(cond, COND_TRIP)
        `CHK(sig_start, 1'b1)
        rchk(REG_MEAS, 32'hf000001e);
        rchk(REG_RATIO_ALARM, 32'd300);
        rchk(REG_RATIO_TRIP, 32'd150);
        want_cur <= 16'd0;
        repeat (3*CYC) @(posedge pclk);
        rchk(REG_REM_TRIP, 32'd0);
        want_cur <= 16'd30;
        wait_for(0);
        // A block pulse between program cycle starts must go unseen
        @(posedge pclk);
        want_blk <= 1'b1;
        @(posedge pclk);
        want_blk <= 1'b0;
        rchk(REG_REM_TRIP, 32'd4);
        rchk(REG_REM_ALARM, 32'd2);
        rchk(REG_EXP_TRIP, 32'd4);
        repeat (CYC) @(posedge pclk);
        rchk(REG_REM_TRIP, 32'd3);
        `CHK(cond, COND_START)
        want_blk <= 1'b1;
        wait_for(1);
        // Remember the first stamp; the next event must be whole program cycles later
        stamp0 = blk_evt_stamp;
        t0 = $time;
        `CHK(disp_evt, 1'b1)
        `CHK(sig_blocked, 1'b1)
        `CHK(sig_start, 1'b0)
        `CHK(blk_evt_cur, 16'd30)
        `CHK(blk_evt_type, 2'b11)
        rchk(REG_REM_TRIP, 32'd0);
        rchk(REG_BLK_EVT, 32'h3001e);
        want_cur <= 16'd0;
        want_blk <= 1'b0;
        repeat (3*CYC) @(posedge pclk);
        // Pick-up and block arrive together: no start at all
        want_cur <= 16'd30;
        want_blk <= 1'b1;
        wait_for(1);
        `CHK(blk_evt_stamp - stamp0, 32'(($time - t0) / (25*CYC)))
        repeat (3*CYC) @(posedge pclk);
        #1;
        `CHK(cond, COND_BLOCKED)
        `CHK(sig_start, 1'b0)
        apb(1'b1, REG_DELAY_TRIP, 32'd100);
        apb(1'b1, REG_HARM_LIMIT, 32'd50);
        want_blk <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            apb(1'b1, REG_CTRL, {24'h0, t_ctrl[i]});
            want_harm <= t_harm[i];
            repeat (3*CYC) @(posedge pclk);
            #1;
            `CHK(cond, t_cond[i])
            `CHK(ln_mode, t_ctrl[i][6:4])
        end
        rchk(REG_EXP_ALARM, 32'd2);
        apb(1'b1, REG_CTRL, 32'h60);
        repeat (2) @(posedge pclk);
        #1;
        `CHK(ln_mode, LN_OFF)
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
